// *** tb/stp_ext_pin_model.sv ***
`timescale 1ns/100ps
module stp_ext_pin_model #(
    parameter int HALF = 3
) (
    input wire logic clk_i,
    input wire logic go_i,
    output logic pin_o
);
    int ph;
    initial begin
        pin_o = 1'b0;
        ph = 0;
    end
    // Phases of HALF cycles, slower than clock / 2.5
    // Pin held still while idle, so select changes see a steady pin
    always @(posedge clk_i) begin
        if (go_i) begin
            ph <= (ph == HALF - 1) ? 0 : ph + 1;
            if (ph == HALF - 1) begin
                pin_o <= ~pin_o;
            end
        end
    end
endmodule

// *** tb/test_shared_timer_prescaler.sv ***
`timescale 1ns/100ps
module test_shared_timer_prescaler
    import stp_pkg::*;
;
    logic clk, arst_n, io_s, wr_s, rd_s, go, pin, srst, arst, hold;
    logic [7:0] addr, wdata, rdata, d;
    logic [2:0] cs0, cs1, cs3, tick;
    logic [9:0] pre;
    int errors, n_tests, cnt[3], base[3];
    int sh[4] = '{3, 6, 8, 10};
    stp_prescaler i_stp_prescaler (.CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr),
        .IO_SPACE_I(io_s), .WR_I(wr_s), .RD_I(rd_s), .WDATA_I(wdata), .RDATA_O(rdata),
        .CS0_I(cs0), .CS1_I(cs1), .CS3_I(cs3), .EXT0_PIN_I(pin), .EXT1_PIN_I(pin),
        .EXT3_PIN_I(pin), .TICK_O(tick), .PRESCALE_O(pre), .SHARED_RST_O(srst),
        .ASYNC_RST_O(arst), .SYNC_HOLD_O(hold));
    stp_ext_pin_model i_stp_ext_pin_model (.clk_i(clk), .go_i(go), .pin_o(pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        io_s <= io;
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic io, input logic [7:0] a);
        @(posedge clk);
        io_s <= io;
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i] <= cnt[i] + int'(tick[i]);
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        close_out();
    end
    initial begin
        {arst_n, io_s, wr_s, rd_s, go, addr, wdata, cs0, cs1, cs3} = '0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(1'b0, 8'h43);
        check("reset value", d, STP_GTC_RESET);
        wr(1'b1, 8'h23, 8'h83);
        rd(1'b0, 8'h43);
        check("hold image", d, 8'h83);
        rd(1'b0, 8'h23);
        check("unmapped read", d, 8'h00);
        repeat (20) @(posedge clk);
        #1 check("held prescaler", pre, 10'h000);
        check("reset kept", {arst, srst}, 2'h3);
        wr(1'b0, 8'h43, 8'h00);
        repeat (2) @(posedge clk);
        #1 check("reset released", {hold, arst, srst}, 3'h0);
        wr(1'b0, 8'h43, 8'h01);
        #1 check("reset pulse", srst, 1'b1);
        @(posedge clk);
        #1 check("reset self clear", srst, 1'b0);
        @(posedge clk);
        #1 check("prescaler restart", pre < 10'h003, 1'b1);
        wr(1'b0, 8'h43, 8'h7C);
        rd(1'b1, 8'h23);
        check("unused bits", d, 8'h00);
        $display("test register done");
        cs1 <= STP_CS_DIRECT;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            cs0 <= 3'(2 + k);
            repeat (4) @(posedge clk);
            #1 base = cnt;
            repeat (2048) @(posedge clk);
            #1 check("tap ticks", cnt[0] - base[0], 2048 >> sh[k]);
            check("direct ticks", cnt[1] - base[1], 2048);
            check("stopped ticks", cnt[2] - base[2], 0);
        end
        $display("test taps done");
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            cs0 <= e ? STP_CS_EXT_FALL : STP_CS_EXT_RISE;
            cs1 <= e ? STP_CS_EXT_FALL : STP_CS_EXT_RISE;
            cs3 <= e ? STP_CS_EXT_FALL : STP_CS_EXT_RISE;
            repeat (3) @(posedge clk);
            #1 base = cnt;
            @(posedge clk);
            go <= 1'b1;
            repeat (30) @(posedge clk);
            go <= 1'b0;
            repeat (8) @(posedge clk);
            for (int i = 0; i < 3; i++) begin
                #1 check("pin edge ticks", cnt[i] - base[i], 5);
            end
        end
        $display("test external done");
        close_out();
    end
endmodule

// *** verilog/stp_pin_sync.sv ***
`timescale 1ns/100ps
module stp_pin_sync
    import stp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic latch_q;
    logic sync_reg;
    logic sync_next;
    logic last_reg;
    logic last_next;

    // Latch catches pin in high phase; half-cycle of the latency budget
    always_latch begin
        if (clk_i) begin
            // Non-blocking so the flop sees the value held through the low phase
            latch_q <= pin_i;
        end
    end

    always_comb begin
        sync_next = latch_q;
        last_next = sync_reg;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign level_o = sync_reg;
    assign rise_o = sync_reg & ~last_reg;
    assign fall_o = ~sync_reg & last_reg;
endmodule

// *** verilog/stp_pkg.sv ***
package stp_pkg;
    localparam int STP_NUM_TIMERS = 3;
    localparam logic [7:0] STP_GTC_DATA_ADDR = 8'h43;
    localparam logic [7:0] STP_IO_OFFSET = 8'h20;
    localparam logic [7:0] STP_GTC_IO_ADDR = STP_GTC_DATA_ADDR - STP_IO_OFFSET;
    localparam logic [7:0] STP_GTC_RESET = 8'h00;
    localparam int STP_BIT_HOLD = 7;
    localparam int STP_BIT_ASYNC_RST = 1;
    localparam int STP_BIT_SHARED_RST = 0;
    localparam logic [2:0] STP_CS_STOP = 3'h0;
    localparam logic [2:0] STP_CS_DIRECT = 3'h1;
    localparam logic [2:0] STP_CS_DIV8 = 3'h2;
    localparam logic [2:0] STP_CS_DIV64 = 3'h3;
    localparam logic [2:0] STP_CS_DIV256 = 3'h4;
    localparam logic [2:0] STP_CS_DIV1024 = 3'h5;
    localparam logic [2:0] STP_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] STP_CS_EXT_RISE = 3'h7;
    localparam int STP_PRE_W = 10;
    localparam logic [9:0] STP_TAP8_MASK = 10'h007;
    localparam logic [9:0] STP_TAP64_MASK = 10'h03F;
    localparam logic [9:0] STP_TAP256_MASK = 10'h0FF;
    localparam logic [9:0] STP_TAP1024_MASK = 10'h3FF;
endpackage

// *** verilog/stp_prescaler.sv ***
`timescale 1ns/100ps
module stp_prescaler
    import stp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic IO_SPACE_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] WDATA_I,
    output logic [7:0] RDATA_O,
    input wire logic [2:0] CS0_I,
    input wire logic [2:0] CS1_I,
    input wire logic [2:0] CS3_I,
    input wire logic EXT0_PIN_I,
    input wire logic EXT1_PIN_I,
    input wire logic EXT3_PIN_I,
    output logic [2:0] TICK_O,
    output logic [9:0] PRESCALE_O,
    output logic SHARED_RST_O,
    output logic ASYNC_RST_O,
    output logic SYNC_HOLD_O
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] cnt);
        logic hit;
        hit = 1'b0;
        unique case (cs)
            STP_CS_DIV8: hit = (cnt & STP_TAP8_MASK) == STP_TAP8_MASK;
            STP_CS_DIV64: hit = (cnt & STP_TAP64_MASK) == STP_TAP64_MASK;
            STP_CS_DIV256: hit = (cnt & STP_TAP256_MASK) == STP_TAP256_MASK;
            STP_CS_DIV1024: hit = (cnt & STP_TAP1024_MASK) == STP_TAP1024_MASK;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic tick_sel(input logic [2:0] cs, input logic [9:0] cnt,
                                      input logic halted, input logic rise,
                                      input logic fall);
        logic t;
        t = 1'b0;
        unique case (cs)
            STP_CS_STOP: t = 1'b0;
            STP_CS_DIRECT: t = 1'b1;
            STP_CS_EXT_FALL: t = fall;
            STP_CS_EXT_RISE: t = rise;
            default: t = !halted && tap_hit(cs, cnt);
        endcase
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [9:0] pre_reg;
    logic [9:0] pre_next;
    logic hold_reg;
    logic hold_next;
    logic srst_reg;
    logic srst_next;
    logic arst_reg;
    logic arst_next;
    logic [2:0] tick_reg;
    logic [2:0] tick_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic hit;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [2:0] pins;

    assign pins = {EXT3_PIN_I, EXT1_PIN_I, EXT0_PIN_I};

    genvar g;
    generate
        for (g = 0; g < STP_NUM_TIMERS; g++) begin : g_sync
            stp_pin_sync u_sync (
                .clk_i(CLK_I),
                .arst_n_i(ARST_N_I),
                .pin_i(pins[g]),
                .level_o(),
                .rise_o(rise[g]),
                .fall_o(fall[g])
            );
        end
    endgenerate

    // Both address spaces decode to the one register
    assign hit = IO_SPACE_I ? (ADDR_I == STP_GTC_IO_ADDR) : (ADDR_I == STP_GTC_DATA_ADDR);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        hold_next = hold_reg;
        srst_next = srst_reg;
        arst_next = arst_reg;
        if (WR_I && hit) begin
            hold_next = WDATA_I[STP_BIT_HOLD];
            srst_next = WDATA_I[STP_BIT_SHARED_RST];
            arst_next = WDATA_I[STP_BIT_ASYNC_RST];
        end else if (!hold_reg) begin
            srst_next = 1'b0;
            arst_next = 1'b0;
        end
        // Hold kept: reset bits retain written value
    end

    always_comb begin
        // Free running, blind to selects; only the reset bit stops it
        if (srst_reg) begin
            pre_next = '0;
        end else begin
            pre_next = pre_reg + 10'h001;
        end
        for (int i = 0; i < STP_NUM_TIMERS; i++) begin
            tick_next[i] = 1'b0;
        end
        tick_next[0] = tick_sel(CS0_I, pre_reg, srst_reg, rise[0], fall[0]);
        tick_next[1] = tick_sel(CS1_I, pre_reg, srst_reg, rise[1], fall[1]);
        tick_next[2] = tick_sel(CS3_I, pre_reg, srst_reg, rise[2], fall[2]);
        rdata_next = 8'h00;
        if (RD_I && hit) begin
            rdata_next[STP_BIT_HOLD] = hold_reg;
            rdata_next[STP_BIT_ASYNC_RST] = arst_reg;
            rdata_next[STP_BIT_SHARED_RST] = srst_reg;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pre_reg <= '0;
            hold_reg <= STP_GTC_RESET[STP_BIT_HOLD];
            srst_reg <= STP_GTC_RESET[STP_BIT_SHARED_RST];
            arst_reg <= STP_GTC_RESET[STP_BIT_ASYNC_RST];
            tick_reg <= '0;
            rdata_reg <= STP_GTC_RESET;
        end else begin
            pre_reg <= pre_next;
            hold_reg <= hold_next;
            srst_reg <= srst_next;
            arst_reg <= arst_next;
            tick_reg <= tick_next;
            rdata_reg <= rdata_next;
        end
    end

    assign TICK_O = tick_reg;
    assign PRESCALE_O = pre_reg;
    assign SHARED_RST_O = srst_reg;
    assign ASYNC_RST_O = arst_reg;
    assign SYNC_HOLD_O = hold_reg;
    assign RDATA_O = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    direct_tick_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        CS0_I == STP_CS_DIRECT |=> TICK_O[0]) else $error("direct tick missing");
    stop_tick_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        CS1_I == STP_CS_STOP |=> !TICK_O[1]) else $error("stopped timer ticked");
    div8_tick_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CS0_I == STP_CS_DIV8) && !srst_reg && pre_reg[2:0] == 3'h7 |=> TICK_O[0])
        else $error("div8 tick missing");
    div8_quiet_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CS0_I == STP_CS_DIV8) && pre_reg[2:0] != 3'h7 |=> !TICK_O[0])
        else $error("div8 spurious tick");
    pre_run_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !srst_reg |=> pre_reg == $past(pre_reg) + 10'h001)
        else $error("prescaler not free running");
    pre_reset_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        srst_reg |=> pre_reg == 10'h000) else $error("prescaler not reset");
    srst_clear_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        srst_reg && !hold_reg && !(WR_I && hit) |=> !srst_reg)
        else $error("reset bit not self cleared");
    hold_keep_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        hold_reg && !(WR_I && hit) |=> $stable(srst_reg) && $stable(arst_reg))
        else $error("reset bits lost under hold");
    hold_release_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        WR_I && hit && !WDATA_I[STP_BIT_HOLD] && hold_reg ##1 !(WR_I && hit)
        |=> !srst_reg && !arst_reg) else $error("release left resets");
    ext_rise_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        CS3_I == STP_CS_EXT_RISE && rise[2] |=> TICK_O[2])
        else $error("rising edge tick missing");
    ext_fall_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        CS3_I == STP_CS_EXT_FALL && !fall[2] |=> !TICK_O[2])
        else $error("falling tick without edge");
    io_alias_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        RD_I && IO_SPACE_I && ADDR_I == 8'h23 |=> RDATA_O[STP_BIT_HOLD] == $past(hold_reg))
        else $error("io alias read wrong");
endmodule
